// ---- core/dtc_top.sv ----
/*
  dtc_top: control and mode logic of two timer/counters and the two
  external interrupt flags, with count bytes and an interrupt status block.
  Assumes a single-cycle register port on core_clk (125 MHz) and service
  acknowledge pulses from the interrupt controller.
*/
// Behaviour
// R1: timer1 gating: run bit, optionally ext pin high
// R2: timer0 gating likewise with its pin
// R3: timer1 source: prescaled clock or pin falls
// R4: timer0 source: prescaled clock or pin falls
// R5: timer1 mode 1 is 16-bit cascade
// R6: timer1 mode 2 low byte reloads high
// R7: timer0 mode 0 high byte, 5-bit prescaler
// R8: timer0 mode 1 is 16-bit cascade
// R9: timer0 mode 2 low byte reloads high
// R10: timer0 mode 3 splits, high uses timer1 bits
// R11: ext irq1 flag set; edge clears on service
// R12: ext irq0 flag set; edge clears on service
// R13: ext irq1 type: low level or falling edge
// R14: ext irq0 type: low level or falling edge
// R15: overflow flag set, cleared on vectoring
// R16: timer1 mode 3 halts, holds count
// R17: timer1 mode 0 modulo-32 prescaler, upper ignored
// R18: software stops timer before changing mode
`timescale 1ns/10ps
module dtc_top
  import dtc_pkg::*;
(
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire logic         ce,
  // register port
  input  wire dtc_bus_req_t bus_req,
  output      logic [7:0]   rd_data,
  // external pins
  input  wire logic         ext_irq0_pin_n,
  input  wire logic         ext_irq1_pin_n,
  input  wire logic         timer0_count_pin,
  input  wire logic         timer1_count_pin,
  // interrupt controller
  input  wire dtc_irq_vec_t irq_ack,
  output      dtc_irq_vec_t irq_req,
  output      logic         irq
);

  // synchronised pins: [0] irq0, [1] irq1, [2] count0, [3] count1
  logic [3:0] pin_sync, pin_prev, pin_fall;
  logic       tick;
  // registers
  logic       tf1, tr1, tf0, tr0;
  logic [1:0] ext_flag, ext_type;
  logic [7:0] timer_mode_select;
  logic [7:0] timer0_low_byte, timer0_high_byte, timer1_low_byte, timer1_high_byte;
  logic [3:0] irq_status, irq_mask;
  // decoded mode fields
  logic [1:0] mode0, mode1;
  logic       timer0_pin_gating, timer1_pin_gating, src0, src1, split0;
  // counting terms
  logic       run0, run1, inc0, inc1, inc_high0;
  logic       ovf0, ovf1, ovf_high0, set_tf0, set_tf1;
  logic [1:0] set_ext;
  // register strobes
  logic       wr_control, wr_mode, wr_tl0, wr_th0, wr_tl1, wr_th1, wr_status, wr_mask;

  dtc_pin_sync #(
    .WIDTH(4)
  ) u_pin_sync (
    .core_clk(core_clk),
    .reset   (reset),
    .ce      (ce),
    .pin_in  ({timer1_count_pin, timer0_count_pin, ext_irq1_pin_n, ext_irq0_pin_n}),
    .pin_sync(pin_sync)
  );

  dtc_prescaler u_prescaler (
    .core_clk(core_clk),
    .reset   (reset),
    .ce      (ce),
    .tick    (tick)
  );

  // edge detection reads only the synchronised copy
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pin_prev <= 4'hF;
    end else if (ce) begin
      pin_prev <= pin_sync;
    end
  end

  assign pin_fall = pin_prev & ~pin_sync;

  assign wr_control = bus_req.wr && (bus_req.addr == TIMER_CONTROL_OFFSET);
  assign wr_mode    = bus_req.wr && (bus_req.addr == TIMER_MODE_SELECT_OFFSET);
  assign wr_tl0     = bus_req.wr && (bus_req.addr == TIMER0_LOW_BYTE_OFFSET);
  assign wr_th0     = bus_req.wr && (bus_req.addr == TIMER0_HIGH_BYTE_OFFSET);
  assign wr_tl1     = bus_req.wr && (bus_req.addr == TIMER1_LOW_BYTE_OFFSET);
  assign wr_th1     = bus_req.wr && (bus_req.addr == TIMER1_HIGH_BYTE_OFFSET);
  assign wr_status  = bus_req.wr && (bus_req.addr == IRQ_STATUS_OFFSET);
  assign wr_mask    = bus_req.wr && (bus_req.addr == IRQ_MASK_OFFSET);

  // mode changes while running are not guarded; software stops first
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      timer_mode_select <= TIMER_MODE_SELECT_RESET;
    end else if (ce && wr_mode) begin
      timer_mode_select <= bus_req.wdata; // R18
    end
  end

  assign mode0  = {timer_mode_select[TIMER0_FIELD_BASE + MODE_HIGH_POS],
                   timer_mode_select[TIMER0_FIELD_BASE + MODE_LOW_POS]};
  assign mode1  = {timer_mode_select[TIMER1_FIELD_BASE + MODE_HIGH_POS],
                   timer_mode_select[TIMER1_FIELD_BASE + MODE_LOW_POS]};
  assign timer0_pin_gating  = timer_mode_select[TIMER0_FIELD_BASE + PIN_GATING_POS];
  assign timer1_pin_gating  = timer_mode_select[TIMER1_FIELD_BASE + PIN_GATING_POS];
  assign src0   = timer_mode_select[TIMER0_FIELD_BASE + SOURCE_SELECT_POS];
  assign src1   = timer_mode_select[TIMER1_FIELD_BASE + SOURCE_SELECT_POS];
  assign split0 = (mode0 == MODE_SPLIT);

  // gated run: pin high means the active-low line is idle
  assign run0 = tr0 && (!timer0_pin_gating || pin_sync[0]); // R2
  // in split mode timer 1 loses its run bit and runs unless halted or held off by its pin gate
  assign run1 = (split0 || tr1) && (!timer1_pin_gating || pin_sync[1]); // R1

  assign inc0 = run0 && (src0 ? pin_fall[2] : tick); // R4
  assign inc1 = run1 && (mode1 != MODE_SPLIT) && (src1 ? pin_fall[3] : tick); // R3 R16
  // high byte of split timer 0 is always a timer, on timer 1's run bit
  assign inc_high0 = split0 && tr1 && tick; // R10

  always_comb begin
    case (mode0)
      MODE_PRESCALED: ovf0 = inc0 && (&{timer0_high_byte, timer0_low_byte[4:0]});
      MODE_CASCADED:  ovf0 = inc0 && (&{timer0_high_byte, timer0_low_byte});
      MODE_RELOAD:    ovf0 = inc0 && (&timer0_low_byte);
      MODE_SPLIT:     ovf0 = inc0 && (&timer0_low_byte);
      default:        ovf0 = 1'b0;
    endcase
  end

  always_comb begin
    case (mode1)
      MODE_PRESCALED: ovf1 = inc1 && (&{timer1_high_byte, timer1_low_byte[4:0]});
      MODE_CASCADED:  ovf1 = inc1 && (&{timer1_high_byte, timer1_low_byte});
      MODE_RELOAD:    ovf1 = inc1 && (&timer1_low_byte);
      default:        ovf1 = 1'b0;
    endcase
  end

  assign ovf_high0 = inc_high0 && (&timer0_high_byte);

  // timer 0 count bytes; a software write wins over a count
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      timer0_low_byte  <= COUNT_BYTE_RESET;
      timer0_high_byte <= COUNT_BYTE_RESET;
    end else if (ce) begin
      if (inc0) begin
        case (mode0)
          MODE_PRESCALED: begin
            timer0_low_byte[4:0] <= timer0_low_byte[4:0] + 5'h01; // R7
            if (&timer0_low_byte[4:0]) begin
              timer0_high_byte <= timer0_high_byte + 8'h01; // R7
            end
          end
          MODE_CASCADED: begin
            timer0_low_byte <= timer0_low_byte + 8'h01; // R8
            if (&timer0_low_byte) begin
              timer0_high_byte <= timer0_high_byte + 8'h01; // R8
            end
          end
          MODE_RELOAD: begin
            timer0_low_byte <= (&timer0_low_byte) ? timer0_high_byte : timer0_low_byte + 8'h01; // R9
          end
          default: begin
            timer0_low_byte <= timer0_low_byte + 8'h01; // R10
          end
        endcase
      end
      if (inc_high0) begin
        timer0_high_byte <= timer0_high_byte + 8'h01; // R10
      end
      if (wr_tl0) begin
        timer0_low_byte <= bus_req.wdata;
      end
      if (wr_th0) begin
        timer0_high_byte <= bus_req.wdata;
      end
    end
  end

  // timer 1 count bytes; mode 3 never increments, so the count holds
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      timer1_low_byte  <= COUNT_BYTE_RESET;
      timer1_high_byte <= COUNT_BYTE_RESET;
    end else if (ce) begin
      if (inc1) begin
        case (mode1)
          MODE_PRESCALED: begin
            // upper three low-byte bits are left untouched
            timer1_low_byte[4:0] <= timer1_low_byte[4:0] + 5'h01; // R17
            if (&timer1_low_byte[4:0]) begin
              timer1_high_byte <= timer1_high_byte + 8'h01; // R17
            end
          end
          MODE_CASCADED: begin
            timer1_low_byte <= timer1_low_byte + 8'h01; // R5
            if (&timer1_low_byte) begin
              timer1_high_byte <= timer1_high_byte + 8'h01; // R5
            end
          end
          MODE_RELOAD: begin
            timer1_low_byte <= (&timer1_low_byte) ? timer1_high_byte : timer1_low_byte + 8'h01; // R6
          end
          default: begin
            timer1_low_byte <= timer1_low_byte; // R16
          end
        endcase
      end
      if (wr_tl1) begin
        timer1_low_byte <= bus_req.wdata;
      end
      if (wr_th1) begin
        timer1_high_byte <= bus_req.wdata;
      end
    end
  end

  // split timer 0 takes over timer 1's overflow flag
  assign set_tf0 = ovf0;
  assign set_tf1 = split0 ? ovf_high0 : ovf1; // R10

  // overflow flags and run bits; hardware set beats ack and write
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tf1 <= TIMER_CONTROL_RESET[TIMER1_OVERFLOW_FLAG_BIT];
      tr1 <= TIMER_CONTROL_RESET[TIMER1_RUN_BIT_BIT];
      tf0 <= TIMER_CONTROL_RESET[TIMER0_OVERFLOW_FLAG_BIT];
      tr0 <= TIMER_CONTROL_RESET[TIMER0_RUN_BIT_BIT];
    end else if (ce) begin
      if (wr_control) begin
        tr1 <= bus_req.wdata[TIMER1_RUN_BIT_BIT];
        tr0 <= bus_req.wdata[TIMER0_RUN_BIT_BIT];
      end
      if (set_tf0) begin
        tf0 <= 1'b1; // R15
      end else if (irq_ack.timer0) begin
        tf0 <= 1'b0; // R15
      end else if (wr_control) begin
        tf0 <= bus_req.wdata[TIMER0_OVERFLOW_FLAG_BIT];
      end
      if (set_tf1) begin
        tf1 <= 1'b1; // R15
      end else if (irq_ack.timer1) begin
        tf1 <= 1'b0; // R15
      end else if (wr_control) begin
        tf1 <= bus_req.wdata[TIMER1_OVERFLOW_FLAG_BIT];
      end
    end
  end

  // external interrupt flags: flag at control bit 2*i+1, type at 2*i
  for (genvar i = 0; i < 2; i++) begin : g_ext
    // level mode sets while the line is low; edge mode on a falling edge
    assign set_ext[i] = ext_type[i] ? pin_fall[i] : !pin_sync[i]; // R13 R14

    always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
        ext_flag[i] <= TIMER_CONTROL_RESET[2*i+1];
        ext_type[i] <= TIMER_CONTROL_RESET[2*i];
      end else if (ce) begin
        if (wr_control) begin
          ext_type[i] <= bus_req.wdata[2*i];
        end
        if (set_ext[i]) begin
          ext_flag[i] <= 1'b1; // R11 R12
        end else if (ext_type[i] && (i == 0 ? irq_ack.ext0 : irq_ack.ext1)) begin
          ext_flag[i] <= 1'b0; // R11 R12
        end else if (!ext_type[i] && pin_sync[i]) begin
          // level mode flag follows the line once it returns high
          ext_flag[i] <= 1'b0;
        end else if (wr_control) begin
          ext_flag[i] <= bus_req.wdata[2*i+1];
        end
      end
    end
  end

  // sticky status, write one to clear, new event wins
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      irq_status <= IRQ_REG_RESET;
      irq_mask   <= IRQ_REG_RESET;
    end else if (ce) begin
      irq_status <= (irq_status & ~(wr_status ? bus_req.wdata[3:0] : 4'h0))
                  | {set_ext[1], set_ext[0], set_tf1, set_tf0};
      if (wr_mask) begin
        irq_mask <= bus_req.wdata[3:0];
      end
    end
  end

  // registered level, one cycle behind the status bits
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(irq_status & irq_mask);
    end
  end

  assign irq_req = '{ext1: ext_flag[1], ext0: ext_flag[0], timer1: tf1, timer0: tf0};

  // read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rd_data <= 8'h00;
    end else if (ce) begin
      if (bus_req.rd) begin
        case (bus_req.addr)
          TIMER_CONTROL_OFFSET:     rd_data <= {tf1, tr1, tf0, tr0, ext_flag[1], ext_type[1], ext_flag[0],
                                                ext_type[0]};
          TIMER_MODE_SELECT_OFFSET: rd_data <= timer_mode_select;
          TIMER0_LOW_BYTE_OFFSET:   rd_data <= timer0_low_byte;
          TIMER0_HIGH_BYTE_OFFSET:  rd_data <= timer0_high_byte;
          TIMER1_LOW_BYTE_OFFSET:   rd_data <= timer1_low_byte;
          TIMER1_HIGH_BYTE_OFFSET:  rd_data <= timer1_high_byte;
          IRQ_STATUS_OFFSET:        rd_data <= {4'h0, irq_status};
          IRQ_MASK_OFFSET:          rd_data <= {4'h0, irq_mask};
          default:                  rd_data <= 8'h00;
        endcase
      end else begin
        rd_data <= 8'h00;
      end
    end
  end

endmodule

// ---- core/dtc_pkg.sv ----
/*
  dtc_pkg: register offsets, field positions, reset values and carrier
  types for the dual timer control and mode block.
  Assumes an 8-bit register port on the core clock.
*/
package dtc_pkg;

  // register offsets on the 8-bit register port
  localparam logic [7:0] TIMER_CONTROL_OFFSET     = 8'h88;
  localparam logic [7:0] TIMER_MODE_SELECT_OFFSET = 8'h89;
  localparam logic [7:0] TIMER0_LOW_BYTE_OFFSET   = 8'h8A;
  localparam logic [7:0] TIMER1_LOW_BYTE_OFFSET   = 8'h8B;
  localparam logic [7:0] TIMER0_HIGH_BYTE_OFFSET  = 8'h8C;
  localparam logic [7:0] TIMER1_HIGH_BYTE_OFFSET  = 8'h8D;
  localparam logic [7:0] IRQ_STATUS_OFFSET        = 8'h90;
  localparam logic [7:0] IRQ_MASK_OFFSET          = 8'h91;

  // timer_control field positions
  localparam int TIMER1_OVERFLOW_FLAG_BIT = 7;
  localparam int TIMER1_RUN_BIT_BIT       = 6;
  localparam int TIMER0_OVERFLOW_FLAG_BIT = 5;
  localparam int TIMER0_RUN_BIT_BIT       = 4;

  // timer_mode_select field positions (timer 1 nibble is 4 above timer 0)
  localparam int TIMER1_FIELD_BASE = 4;
  localparam int TIMER0_FIELD_BASE = 0;
  localparam int PIN_GATING_POS    = 3;
  localparam int SOURCE_SELECT_POS = 2;
  localparam int MODE_HIGH_POS     = 1;
  localparam int MODE_LOW_POS      = 0;

  // irq status / mask bit positions
  localparam int IRQ_TIMER0_BIT = 0;
  localparam int IRQ_TIMER1_BIT = 1;
  localparam int IRQ_EXT0_BIT   = 2;
  localparam int IRQ_EXT1_BIT   = 3;

  // operating modes
  localparam logic [1:0] MODE_PRESCALED = 2'h0;
  localparam logic [1:0] MODE_CASCADED  = 2'h1;
  localparam logic [1:0] MODE_RELOAD    = 2'h2;
  localparam logic [1:0] MODE_SPLIT     = 2'h3;

  // reset values
  localparam logic [7:0] TIMER_CONTROL_RESET     = 8'h00;
  localparam logic [7:0] TIMER_MODE_SELECT_RESET = 8'h00;
  localparam logic [7:0] COUNT_BYTE_RESET        = 8'h00;
  localparam logic [3:0] IRQ_REG_RESET           = 4'h0;

  // timer input is the peripheral clock divided by this many cycles
  localparam int         TIMER_PRESCALE      = 6;
  localparam logic [2:0] TIMER_PRESCALE_LAST = 3'(TIMER_PRESCALE - 1);

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } dtc_bus_req_t;

  // one bit per interrupt source, used for requests and service acks
  typedef struct packed {
    logic ext1;
    logic ext0;
    logic timer1;
    logic timer0;
  } dtc_irq_vec_t;

endpackage

// ---- core/dtc_pin_sync.sv ----
/*
  dtc_pin_sync: two-flop synchroniser for a group of external pins.
  Assumes pins are asynchronous to core_clk; output is the second flop.
*/
`timescale 1ns/10ps
module dtc_pin_sync
  import dtc_pkg::*;
#(
  parameter int WIDTH = 4
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic             ce,
  // pins
  input  wire logic [WIDTH-1:0] pin_in,
  output      logic [WIDTH-1:0] pin_sync
);

  logic [WIDTH-1:0] meta;

  // reset high matches idle level of active-low pins
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      meta     <= '1;
      pin_sync <= '1;
    end else if (ce) begin
      meta     <= pin_in;
      pin_sync <= meta;
    end
  end

endmodule

// ---- core/dtc_prescaler.sv ----
/*
  dtc_prescaler: divides the peripheral clock into a one-cycle timer tick.
  Assumes a clock enable that freezes the count while low.
*/
`timescale 1ns/10ps
module dtc_prescaler
  import dtc_pkg::*;
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic ce,
  // tick out
  output      logic tick
);

  logic [2:0] count;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      count <= 3'h0;
    end else if (ce) begin
      count <= (count == TIMER_PRESCALE_LAST) ? 3'h0 : count + 3'h1;
    end
  end

  assign tick = ce && (count == TIMER_PRESCALE_LAST);

endmodule

// ---- dv/dtc_top_props.sv ----
/*
  dtc_top_props: port-level assertions for dtc_top, attached by bind.
  Assumes pins are held long enough to pass the sync and that acks hit stopped timers.
*/
`timescale 1ns/10ps
module dtc_top_props
  import dtc_pkg::*;
(
  // clock and reset
  input wire logic         core_clk,
  input wire logic         reset,
  input wire logic         ce,
  // register port
  input wire dtc_bus_req_t bus_req,
  input wire logic [7:0]   rd_data,
  // pins
  input wire logic         ext_irq0_pin_n,
  input wire logic         ext_irq1_pin_n,
  input wire logic         timer0_count_pin,
  input wire logic         timer1_count_pin,
  // interrupt controller
  input wire dtc_irq_vec_t irq_ack,
  input wire dtc_irq_vec_t irq_req,
  input wire logic         irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  property p_reset_quiet;
    disable iff (1'b0) reset |-> rd_data == 8'h00 && !irq && irq_req == 4'h0;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not quiet in reset");
  property p_rd_idle;
    ce && !bus_req.rd |=> rd_data == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_ext0_set;
    $rose(irq_req.ext0) |-> !$past(ext_irq0_pin_n, 2);
  endproperty
  a_ext0_set: assert property (p_ext0_set) else $error("ext0 flag without pin");
  property p_ext1_set;
    $rose(irq_req.ext1) |-> !$past(ext_irq1_pin_n, 2);
  endproperty
  a_ext1_set: assert property (p_ext1_set) else $error("ext1 flag without pin");
  property p_ext0_ack;
    ext_irq0_pin_n [*4] ##0 (ce && irq_ack.ext0) |=> !irq_req.ext0;
  endproperty
  a_ext0_ack: assert property (p_ext0_ack) else $error("ext0 flag kept");
  property p_ext1_ack;
    ext_irq1_pin_n [*4] ##0 (ce && irq_ack.ext1) |=> !irq_req.ext1;
  endproperty
  a_ext1_ack: assert property (p_ext1_ack) else $error("ext1 flag kept");
  property p_tf0_ack;
    ce && irq_req.timer0 && irq_ack.timer0 |=> !irq_req.timer0;
  endproperty
  a_tf0_ack: assert property (p_tf0_ack) else $error("timer0 flag kept after ack");
  property p_tf1_ack;
    ce && irq_req.timer1 && irq_ack.timer1 |=> !irq_req.timer1;
  endproperty
  a_tf1_ack: assert property (p_tf1_ack) else $error("timer1 flag kept after ack");

  c_irq: cover property ($rose(irq));
  c_tf1_ack: cover property (irq_req.timer1 && irq_ack.timer1);
  c_ext1: cover property ($rose(irq_req.ext1));
endmodule

bind dtc_top dtc_top_props u_props (
  .core_clk(core_clk), .reset(reset), .ce(ce), .bus_req(bus_req), .rd_data(rd_data),
  .ext_irq0_pin_n(ext_irq0_pin_n), .ext_irq1_pin_n(ext_irq1_pin_n),
  .timer0_count_pin(timer0_count_pin), .timer1_count_pin(timer1_count_pin),
  .irq_ack(irq_ack), .irq_req(irq_req), .irq(irq));

// ---- dv/dtc_pin_model.sv ----
/*
  dtc_pin_model: far side of dtc_top: event pins, interrupt pins, service acks.
  Assumes one calling process; pins idle high.
*/
`timescale 1ns/10ps
module dtc_pin_model
  import dtc_pkg::*;
(
  // clock
  input wire logic     core_clk,
  // pins
  output logic         ext_irq0_pin_n,
  output logic         ext_irq1_pin_n,
  output logic         timer0_count_pin,
  output logic         timer1_count_pin,
  // service acks
  output dtc_irq_vec_t irq_ack
);
  initial begin
    {ext_irq0_pin_n, ext_irq1_pin_n, timer0_count_pin, timer1_count_pin} = 4'hF;
    irq_ack = '0;
  end
  task set_ext(input int e, input logic v);
    @(posedge core_clk);
    if (e == 0) ext_irq0_pin_n <= v;
    else ext_irq1_pin_n <= v;
  endtask
  // low and high phases of w cycles, wide enough for the two-flop sync
  task pulse(input int t, input int n, input int w);
    repeat (n) begin
      @(posedge core_clk);
      if (t == 0) timer0_count_pin <= 1'b0;
      else timer1_count_pin <= 1'b0;
      repeat (w) @(posedge core_clk);
      if (t == 0) timer0_count_pin <= 1'b1;
      else timer1_count_pin <= 1'b1;
      repeat (w - 1) @(posedge core_clk);
    end
  endtask
  task ack(input logic [3:0] v);
    @(posedge core_clk);
    irq_ack <= v;
    @(posedge core_clk);
    irq_ack <= '0;
  endtask
endmodule

// ---- dv/test_dtc_top.sv ----
/*
  test_dtc_top: self-checking bench for dtc_top with a pin model on the far side.
  Assumes a 125 MHz core_clk and the register map of dtc_pkg.
*/
`timescale 1ns/10ps
module test_dtc_top
  import dtc_pkg::*;
;
  logic         core_clk = 1'b0;
  logic         reset    = 1'b0;
  logic         ce       = 1'b1;
  dtc_bus_req_t bus_req  = '0;
  logic [7:0]   rd_data;
  logic         ext_irq0_pin_n, ext_irq1_pin_n, timer0_count_pin, timer1_count_pin, irq;
  dtc_irq_vec_t irq_ack, irq_req;
  int           fails    = 0;
  int           n_checks = 0;
  int           cyc      = 0;
  int           n;
  logic [7:0]   shadow [logic [7:0]];
  logic [7:0]   regs_q [$] = '{8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h90, 8'h91, 8'h8E};

  dtc_top uut (.core_clk(core_clk), .reset(reset), .ce(ce), .bus_req(bus_req), .rd_data(rd_data),
    .ext_irq0_pin_n(ext_irq0_pin_n), .ext_irq1_pin_n(ext_irq1_pin_n), .timer0_count_pin(timer0_count_pin),
    .timer1_count_pin(timer1_count_pin), .irq_ack(irq_ack), .irq_req(irq_req), .irq(irq));
  dtc_pin_model pm (.core_clk(core_clk), .ext_irq0_pin_n(ext_irq0_pin_n), .ext_irq1_pin_n(ext_irq1_pin_n),
    .timer0_count_pin(timer0_count_pin), .timer1_count_pin(timer1_count_pin), .irq_ack(irq_ack));

  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      close_out();
    end
  end

  task close_out;
    if (fails == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task tick(input int c);
    repeat (c) @(posedge core_clk);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
    if (ce === 1'b1) shadow[a] = d;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    #1 chk(rd_data, exp);
  endtask
  task wait_bit(input int b, input int lim, output int c);
    c = 0;
    while (irq_req[b] !== 1'b1 && c < lim) begin
      @(posedge core_clk);
      #1 c++;
    end
  endtask
  // mode 3 here means timer0 split, high byte running on timer1's run bit
  task run_t(input int t, input int m, input int src);
    int ticks, fb, c;
    logic [7:0] lo, hi, elo, ehi;
    fb = (m == 3) ? 1 : t;
    hi = 8'hFF;
    lo = 8'(8'hF0 + $urandom % 16);
    ticks = 256 - lo;
    elo = 8'h00;
    ehi = 8'h00;
    if (m == 0) begin
      lo = {3'($urandom), 5'(5'h1A + $urandom % 6)};
      ticks = 32 - lo[4:0];
      elo = {lo[7:5], 5'h00};
    end else if (m == 2) begin
      hi = 8'($urandom);
      lo = 8'(8'hF8 + $urandom % 8);
      ticks = 256 - lo;
      elo = hi;
      ehi = hi;
    end else if (m == 3) begin
      hi = 8'(8'hFC + $urandom % 4);
      lo = 8'($urandom);
      ticks = 256 - hi;
      elo = lo;
    end
    wr(8'h89, 8'((src << 2 | m) << (4 * t)));
    wr(8'(8'h8A + t), lo);
    wr(8'(8'h8C + t), hi);
    wr(8'h88, (fb == 1) ? 8'h40 : 8'h10);
    if (src != 0) pm.pulse(t, ticks, 3 + $urandom % 3);
    wait_bit(fb, ticks * 6 + 12, c);
    chk(irq_req[fb], 1'b1);
    if (src == 0) chk(c >= (ticks - 1) * 6, 1'b1);
    wr(8'h88, (fb == 1) ? 8'h80 : 8'h20);
    pm.ack(4'hF);
    rd(8'h88, 8'h00);
    rd(8'(8'h8A + t), elo);
    rd(8'(8'h8C + t), ehi);
    wr(8'h90, 8'h0F);
  endtask

  initial begin
    // raised by an update at time 0 so the asynchronous reset sees an edge
    reset <= 1'b1;
    void'($urandom(60));
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    tick(1);
    foreach (regs_q[i]) rd(regs_q[i], 8'h00);
    // timer 0 kept out of split mode, else timer 1 runs and its bytes move
    for (int i = 1; i < 9; i++) wr(regs_q[i], 8'($urandom) & ((i == 1) ? 8'hFD : 8'hFF));
    for (int i = 1; i < 9; i++) rd(regs_q[i], (i < 6) ? shadow[regs_q[i]] : (i == 7) ? shadow[8'h91] & 8'h0F : 8'h00);
    // a strobe while frozen must not land
    @(posedge core_clk) ce <= 1'b0;
    wr(8'h8A, ~shadow[8'h8A]);
    @(posedge core_clk) ce <= 1'b1;
    rd(8'h8A, shadow[8'h8A]);
    wr(8'h89, 8'h00);
    wr(8'h91, 8'h00);
    for (int t = 0; t < 2; t++)
      for (int m = 0; m < 3; m++)
        for (int s = 0; s < 2; s++) run_t(t, m, s);
    run_t(0, 3, 0);
    wr(8'h89, 8'h30);
    wr(8'h8B, 8'hFF);
    wr(8'h8D, 8'hFF);
    wr(8'h88, 8'h40);
    tick(40);
    chk(irq_req.timer1, 1'b0);
    wr(8'h88, 8'h00);
    rd(8'h8B, 8'hFF);
    for (int t = 0; t < 2; t++) begin
      wr(8'h89, 8'(9 << (4 * t)));
      wr(8'(8'h8A + t), 8'hFE);
      wr(8'(8'h8C + t), 8'hFF);
      pm.set_ext(t, 1'b0);
      wr(8'h88, (t == 1) ? 8'h40 : 8'h10);
      tick(40);
      rd(8'(8'h8A + t), 8'hFE);
      pm.set_ext(t, 1'b1);
      wait_bit(t, 24, n);
      chk(irq_req[t], 1'b1);
      wr(8'h88, 8'h00);
      wr(8'h90, 8'h0F);
    end
    for (int e = 0; e < 2; e++)
      for (int it = 0; it < 2; it++) begin
        wr(8'h88, 8'(it << (2 * e)));
        pm.set_ext(e, 1'b0);
        wait_bit(2 + e, 8, n);
        chk(irq_req[2 + e], 1'b1);
        rd(8'h88, 8'((2 | it) << (2 * e)));
        if (it == 1) begin
          chk(irq, 1'b0);
          wr(8'h91, 8'(4 << e));
          tick(2);
          chk(irq, 1'b1);
          wr(8'h90, 8'(4 << e));
          tick(2);
          chk(irq, 1'b0);
          wr(8'h91, 8'h00);
        end
        pm.ack(4'(4 << e));
        tick(2);
        chk(irq_req[2 + e], 1'(it == 0));
        pm.set_ext(e, 1'b1);
        tick(6);
        chk(irq_req[2 + e], 1'b0);
        wr(8'h90, 8'h0F);
      end
    close_out();
  end
endmodule
